// File: common/csie_pkg.sv
package csie_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses
   localparam logic [7:0]  CSIE_OFS_ENCLR   = 8'h00;
   localparam logic [7:0]  CSIE_OFS_ENSET   = 8'h04;
   localparam logic [7:0]  CSIE_OFS_FLAG    = 8'h08;
   localparam logic [7:0]  CSIE_OFS_GUARD   = 8'h0c;
   localparam logic [7:0]  CSIE_OFS_STATUS  = 8'h10;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int CSIE_BIT_PLL_TIMEOUT   = 17;
   localparam int CSIE_BIT_PLL_LOST      = 16;
   localparam int CSIE_BIT_PLL_GAINED    = 15;
   localparam int CSIE_BIT_BO_SYNC_RDY   = 11;
   localparam int CSIE_BIT_BO_DETECT     = 10;
   localparam int CSIE_BIT_BO_READY      = 9;
   localparam int CSIE_BIT_FLL_REF_STOP  = 8;
   localparam int CSIE_BIT_FLL_COARSE    = 7;
   localparam int CSIE_BIT_FLL_FINE      = 6;
   localparam int CSIE_BIT_FLL_OOB       = 5;
   localparam int CSIE_BIT_FLL_READY     = 4;
   localparam int CSIE_BIT_REF8M_READY   = 3;
   localparam int CSIE_BIT_INT32K_READY  = 2;
   localparam int CSIE_BIT_EXT32K_READY  = 1;
   localparam int CSIE_BIT_XTAL_READY    = 0;

   // Implemented bits 17:15, 11:0
   localparam logic [31:0] CSIE_IMPL_MASK   = 32'h0003_8fff;
   localparam logic [31:0] CSIE_RESET_EN    = 32'h0000_0000;
   localparam logic [31:0] CSIE_RESET_FLAG  = 32'h0000_0000;
   localparam logic        CSIE_RESET_GUARD = 1'b0;

endpackage : csie_pkg

// File: common/csie_wr_if.sv
`timescale 1ns/10ps
interface csie_wr_if;
   logic        set_stb;
   logic        clr_stb;
   logic [31:0] wdata;
   logic [31:0] enable;

   modport ctrl (output set_stb, output clr_stb, output wdata, input enable);
   modport regs (input set_stb, input clr_stb, input wdata, output enable);
endinterface : csie_wr_if

// File: hw/csie_enable_reg.sv
`timescale 1ns/10ps
module csie_enable_reg
   import csie_pkg::*;
(
   input wire logic  clk,
   input wire logic  rst_n,
   csie_wr_if.regs   wr
);

   typedef struct packed {
      logic [31:0] en;
   } csie_en_state_t;

   csie_en_state_t st_r;
   csie_en_state_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      // Zero bits leave the enable untouched
      if (wr.set_stb) begin
         st_nxt.en = st_r.en | (wr.wdata & CSIE_IMPL_MASK);
      end
      if (wr.clr_stb) begin
         st_nxt.en = st_r.en & ~(wr.wdata & CSIE_IMPL_MASK);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r.en <= CSIE_RESET_EN;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign wr.enable = st_r.en;

   a_set_keeps_zero: assert property (@(posedge clk) disable iff (!rst_n)
      wr.set_stb |=> ((st_r.en & ~$past(wr.wdata)) == ($past(st_r.en) & ~$past(wr.wdata))))
      else $error("Set write altered a bit written with zero");
   a_clr_clears: assert property (@(posedge clk) disable iff (!rst_n)
      wr.clr_stb |=> ((st_r.en & $past(wr.wdata)) == 32'h0000_0000))
      else $error("Clear write left an enable set");
   a_set_sets: assert property (@(posedge clk) disable iff (!rst_n)
      wr.set_stb |=> ((st_r.en & $past(wr.wdata) & CSIE_IMPL_MASK)
                      == ($past(wr.wdata) & CSIE_IMPL_MASK)))
      else $error("Set write did not set enable");
   a_unused_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (st_r.en & ~CSIE_IMPL_MASK) == 32'h0000_0000)
      else $error("Unused enable bit is set");

endmodule : csie_enable_reg

// File: hw/csie_top.sv
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - A zero written to either enable register leaves that enable unchanged.
// - A one written to the clear-style register disables that interrupt.
// - A one written to the set-style register enables that interrupt.
// - Interrupt is requested while any enabled source has its flag set.
// - PLL timeout, lock-lost and lock-gained enables sit at bits 17, 16, 15.
// - Brown-out sync-ready, detect, ready at 11, 10, 9; FLL ref-stopped at 8.
// - FLL coarse, fine, bounds, ready at 7..4; oscillator readies at 3..0.
// - Enable bits read one when enabled, and reset to all zeros.
// - A flag sets on a rising edge of its status bit, whatever the enable.
// - Writing one to a flag clears it; zeros are ignored.
// - Enable writes are blocked while the write guard is active.
////////////////////////////////////////////////////////////////////////////////
module csie_top
   import csie_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        RESET_N,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR_STB,
   input  wire logic        RD_STB,
   input  wire logic [31:0] SRC_STATUS,
   output logic      [31:0] RDATA,
   output logic             IRQ
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [31:0] rdata;
      logic        irq;
      logic [31:0] flag;
      logic [31:0] status_d;
      logic        guard;
   } csie_state_t;

   csie_state_t st_r;
   csie_state_t st_nxt;

   csie_wr_if   wr_bus ();

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   logic        en_write_ok;
   logic [31:0] enables;
   logic [31:0] rise;

   assign enables     = wr_bus.enable;
   assign en_write_ok = WR_STB && !st_r.guard;
   assign wr_bus.set_stb = en_write_ok && hit(ADDR, CSIE_OFS_ENSET);
   assign wr_bus.clr_stb = en_write_ok && hit(ADDR, CSIE_OFS_ENCLR);
   assign wr_bus.wdata   = WDATA;
   assign rise = SRC_STATUS & ~st_r.status_d & CSIE_IMPL_MASK;

   ////////////////////////////////////////////////////////////////////////////
   // Enable storage

   csie_enable_reg u_enable (
      .clk   (CORE_CLK),
      .rst_n (RESET_N),
      .wr    (wr_bus)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      st_nxt          = st_r;
      st_nxt.status_d = SRC_STATUS;
      // Set beats clear in the same cycle
      if (WR_STB && hit(ADDR, CSIE_OFS_FLAG)) begin
         st_nxt.flag = st_r.flag & ~(WDATA & CSIE_IMPL_MASK);
      end
      st_nxt.flag = st_nxt.flag | rise;
      if (WR_STB && hit(ADDR, CSIE_OFS_GUARD)) begin
         st_nxt.guard = WDATA[0];
      end
      st_nxt.irq   = |(st_nxt.flag & enables);
      st_nxt.rdata = 32'h0000_0000;
      if (RD_STB) begin
         case (ADDR)
            CSIE_OFS_ENCLR:  st_nxt.rdata = enables & CSIE_IMPL_MASK;
            CSIE_OFS_ENSET:  st_nxt.rdata = enables & CSIE_IMPL_MASK;
            CSIE_OFS_FLAG:   st_nxt.rdata = st_r.flag;
            CSIE_OFS_GUARD:  st_nxt.rdata = {31'h0000_0000, st_r.guard};
            CSIE_OFS_STATUS: st_nxt.rdata = SRC_STATUS & CSIE_IMPL_MASK;
            default:         st_nxt.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st_r.rdata    <= 32'h0000_0000;
         st_r.irq      <= 1'b0;
         st_r.flag     <= CSIE_RESET_FLAG;
         st_r.status_d <= 32'h0000_0000;
         st_r.guard    <= CSIE_RESET_GUARD;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign RDATA = st_r.rdata;
   assign IRQ   = st_r.irq;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   sequence s_rise(int b);
      !SRC_STATUS[b] ##1 SRC_STATUS[b];
   endsequence

   default clocking cb_core @(posedge CORE_CLK); endclocking
   default disable iff (!RESET_N);

   a_irq_needs_enable: assert property (
      $past(WR_STB) || (IRQ == |(st_r.flag & enables)))
      else $error("Interrupt level disagrees with flags and enables");

   a_irq_follows: assert property (
      ((st_nxt.flag & enables) != 32'h0000_0000) |=> IRQ)
      else $error("Enabled flag did not raise interrupt");

   a_flag_on_rise: assert property (
      s_rise(CSIE_BIT_PLL_TIMEOUT) |=> st_r.flag[CSIE_BIT_PLL_TIMEOUT])
      else $error("Status rise did not set flag");

   a_flag_rise_xtal: assert property (
      s_rise(CSIE_BIT_XTAL_READY) |=> st_r.flag[CSIE_BIT_XTAL_READY])
      else $error("Oscillator ready rise did not set flag");

   a_flag_clear: assert property (
      (WR_STB && ADDR == CSIE_OFS_FLAG && WDATA[CSIE_BIT_BO_DETECT]
       && !(SRC_STATUS[CSIE_BIT_BO_DETECT] && !st_r.status_d[CSIE_BIT_BO_DETECT]))
      |=> !st_r.flag[CSIE_BIT_BO_DETECT])
      else $error("Write one did not clear flag");

   a_guard_blocks: assert property (
      (st_r.guard && WR_STB) |=> $stable(enables))
      else $error("Guarded enable write took effect");

   a_read_enable: assert property (
      (RD_STB && ADDR == CSIE_OFS_ENSET) |=> (RDATA == ($past(enables) & CSIE_IMPL_MASK)))
      else $error("Enable readback wrong");

   a_bit_fine: assert property (
      (WR_STB && !st_r.guard && ADDR == CSIE_OFS_ENSET && WDATA == 32'h0000_0040)
      |=> enables[CSIE_BIT_FLL_FINE])
      else $error("Fine lock enable not at its bit");

   ////////////////////////////////////////////////////////////////////////////
   // Set per field

   a_set_pll_timeout: assert property (
      (wr_bus.set_stb && WDATA[CSIE_BIT_PLL_TIMEOUT]) |=> enables[CSIE_BIT_PLL_TIMEOUT])
      else $error("Set missed pll timeout");

   a_set_pll_lost: assert property (
      (wr_bus.set_stb && WDATA[CSIE_BIT_PLL_LOST]) |=> enables[CSIE_BIT_PLL_LOST])
      else $error("Set missed pll lost");

   a_set_pll_gained: assert property (
      (wr_bus.set_stb && WDATA[CSIE_BIT_PLL_GAINED]) |=> enables[CSIE_BIT_PLL_GAINED])
      else $error("Set missed pll gained");

   a_set_bo_sync: assert property (
      (wr_bus.set_stb && WDATA[CSIE_BIT_BO_SYNC_RDY]) |=> enables[CSIE_BIT_BO_SYNC_RDY])
      else $error("Set missed brown-out sync");

   a_set_bo_detect: assert property (
      (wr_bus.set_stb && WDATA[CSIE_BIT_BO_DETECT]) |=> enables[CSIE_BIT_BO_DETECT])
      else $error("Set missed brown-out detect");

   a_set_bo_ready: assert property (
      (wr_bus.set_stb && WDATA[CSIE_BIT_BO_READY]) |=> enables[CSIE_BIT_BO_READY])
      else $error("Set missed brown-out ready");

   a_set_fll_ref: assert property (
      (wr_bus.set_stb && WDATA[CSIE_BIT_FLL_REF_STOP]) |=> enables[CSIE_BIT_FLL_REF_STOP])
      else $error("Set missed fll ref stop");

   a_set_fll_coarse: assert property (
      (wr_bus.set_stb && WDATA[CSIE_BIT_FLL_COARSE]) |=> enables[CSIE_BIT_FLL_COARSE])
      else $error("Set missed fll coarse");

   a_set_fll_fine: assert property (
      (wr_bus.set_stb && WDATA[CSIE_BIT_FLL_FINE]) |=> enables[CSIE_BIT_FLL_FINE])
      else $error("Set missed fll fine");

   a_set_fll_oob: assert property (
      (wr_bus.set_stb && WDATA[CSIE_BIT_FLL_OOB]) |=> enables[CSIE_BIT_FLL_OOB])
      else $error("Set missed fll bounds");

   a_set_fll_ready: assert property (
      (wr_bus.set_stb && WDATA[CSIE_BIT_FLL_READY]) |=> enables[CSIE_BIT_FLL_READY])
      else $error("Set missed fll ready");

   a_set_ref8m: assert property (
      (wr_bus.set_stb && WDATA[CSIE_BIT_REF8M_READY]) |=> enables[CSIE_BIT_REF8M_READY])
      else $error("Set missed ref8m ready");

   a_set_int32k: assert property (
      (wr_bus.set_stb && WDATA[CSIE_BIT_INT32K_READY]) |=> enables[CSIE_BIT_INT32K_READY])
      else $error("Set missed int32k ready");

   a_set_ext32k: assert property (
      (wr_bus.set_stb && WDATA[CSIE_BIT_EXT32K_READY]) |=> enables[CSIE_BIT_EXT32K_READY])
      else $error("Set missed ext32k ready");

   a_set_xtal: assert property (
      (wr_bus.set_stb && WDATA[CSIE_BIT_XTAL_READY]) |=> enables[CSIE_BIT_XTAL_READY])
      else $error("Set missed xtal ready");

   ////////////////////////////////////////////////////////////////////////////
   // Clear per field

   a_clr_pll_timeout: assert property (
      (wr_bus.clr_stb && WDATA[CSIE_BIT_PLL_TIMEOUT]) |=> !enables[CSIE_BIT_PLL_TIMEOUT])
      else $error("Clear missed pll timeout");

   a_clr_pll_lost: assert property (
      (wr_bus.clr_stb && WDATA[CSIE_BIT_PLL_LOST]) |=> !enables[CSIE_BIT_PLL_LOST])
      else $error("Clear missed pll lost");

   a_clr_pll_gained: assert property (
      (wr_bus.clr_stb && WDATA[CSIE_BIT_PLL_GAINED]) |=> !enables[CSIE_BIT_PLL_GAINED])
      else $error("Clear missed pll gained");

   a_clr_bo_sync: assert property (
      (wr_bus.clr_stb && WDATA[CSIE_BIT_BO_SYNC_RDY]) |=> !enables[CSIE_BIT_BO_SYNC_RDY])
      else $error("Clear missed brown-out sync");

   a_clr_bo_detect: assert property (
      (wr_bus.clr_stb && WDATA[CSIE_BIT_BO_DETECT]) |=> !enables[CSIE_BIT_BO_DETECT])
      else $error("Clear missed brown-out detect");

   a_clr_bo_ready: assert property (
      (wr_bus.clr_stb && WDATA[CSIE_BIT_BO_READY]) |=> !enables[CSIE_BIT_BO_READY])
      else $error("Clear missed brown-out ready");

   a_clr_fll_ref: assert property (
      (wr_bus.clr_stb && WDATA[CSIE_BIT_FLL_REF_STOP]) |=> !enables[CSIE_BIT_FLL_REF_STOP])
      else $error("Clear missed fll ref stop");

   a_clr_fll_coarse: assert property (
      (wr_bus.clr_stb && WDATA[CSIE_BIT_FLL_COARSE]) |=> !enables[CSIE_BIT_FLL_COARSE])
      else $error("Clear missed fll coarse");

   a_clr_fll_fine: assert property (
      (wr_bus.clr_stb && WDATA[CSIE_BIT_FLL_FINE]) |=> !enables[CSIE_BIT_FLL_FINE])
      else $error("Clear missed fll fine");

   a_clr_fll_oob: assert property (
      (wr_bus.clr_stb && WDATA[CSIE_BIT_FLL_OOB]) |=> !enables[CSIE_BIT_FLL_OOB])
      else $error("Clear missed fll bounds");

   a_clr_fll_ready: assert property (
      (wr_bus.clr_stb && WDATA[CSIE_BIT_FLL_READY]) |=> !enables[CSIE_BIT_FLL_READY])
      else $error("Clear missed fll ready");

   a_clr_ref8m: assert property (
      (wr_bus.clr_stb && WDATA[CSIE_BIT_REF8M_READY]) |=> !enables[CSIE_BIT_REF8M_READY])
      else $error("Clear missed ref8m ready");

   a_clr_int32k: assert property (
      (wr_bus.clr_stb && WDATA[CSIE_BIT_INT32K_READY]) |=> !enables[CSIE_BIT_INT32K_READY])
      else $error("Clear missed int32k ready");

   a_clr_ext32k: assert property (
      (wr_bus.clr_stb && WDATA[CSIE_BIT_EXT32K_READY]) |=> !enables[CSIE_BIT_EXT32K_READY])
      else $error("Clear missed ext32k ready");

   a_clr_xtal: assert property (
      (wr_bus.clr_stb && WDATA[CSIE_BIT_XTAL_READY]) |=> !enables[CSIE_BIT_XTAL_READY])
      else $error("Clear missed xtal ready");

   ////////////////////////////////////////////////////////////////////////////
   // Flag set per field

   a_rise_pll_lost: assert property (
      s_rise(CSIE_BIT_PLL_LOST) |=> st_r.flag[CSIE_BIT_PLL_LOST])
      else $error("Rise missed pll lost");

   a_rise_pll_gained: assert property (
      s_rise(CSIE_BIT_PLL_GAINED) |=> st_r.flag[CSIE_BIT_PLL_GAINED])
      else $error("Rise missed pll gained");

   a_rise_bo_sync: assert property (
      s_rise(CSIE_BIT_BO_SYNC_RDY) |=> st_r.flag[CSIE_BIT_BO_SYNC_RDY])
      else $error("Rise missed brown-out sync");

   a_rise_bo_detect: assert property (
      s_rise(CSIE_BIT_BO_DETECT) |=> st_r.flag[CSIE_BIT_BO_DETECT])
      else $error("Rise missed brown-out detect");

   a_rise_bo_ready: assert property (
      s_rise(CSIE_BIT_BO_READY) |=> st_r.flag[CSIE_BIT_BO_READY])
      else $error("Rise missed brown-out ready");

   a_rise_fll_ref: assert property (
      s_rise(CSIE_BIT_FLL_REF_STOP) |=> st_r.flag[CSIE_BIT_FLL_REF_STOP])
      else $error("Rise missed fll ref stop");

   a_rise_fll_coarse: assert property (
      s_rise(CSIE_BIT_FLL_COARSE) |=> st_r.flag[CSIE_BIT_FLL_COARSE])
      else $error("Rise missed fll coarse");

   a_rise_fll_fine: assert property (
      s_rise(CSIE_BIT_FLL_FINE) |=> st_r.flag[CSIE_BIT_FLL_FINE])
      else $error("Rise missed fll fine");

   a_rise_fll_oob: assert property (
      s_rise(CSIE_BIT_FLL_OOB) |=> st_r.flag[CSIE_BIT_FLL_OOB])
      else $error("Rise missed fll bounds");

   a_rise_fll_ready: assert property (
      s_rise(CSIE_BIT_FLL_READY) |=> st_r.flag[CSIE_BIT_FLL_READY])
      else $error("Rise missed fll ready");

   a_rise_ref8m: assert property (
      s_rise(CSIE_BIT_REF8M_READY) |=> st_r.flag[CSIE_BIT_REF8M_READY])
      else $error("Rise missed ref8m ready");

   a_rise_int32k: assert property (
      s_rise(CSIE_BIT_INT32K_READY) |=> st_r.flag[CSIE_BIT_INT32K_READY])
      else $error("Rise missed int32k ready");

   a_rise_ext32k: assert property (
      s_rise(CSIE_BIT_EXT32K_READY) |=> st_r.flag[CSIE_BIT_EXT32K_READY])
      else $error("Rise missed ext32k ready");

   ////////////////////////////////////////////////////////////////////////////
   // Flag clear per field

   a_fclr_pll_timeout: assert property (
      (WR_STB && hit(ADDR, CSIE_OFS_FLAG) && WDATA[CSIE_BIT_PLL_TIMEOUT]
       && !rise[CSIE_BIT_PLL_TIMEOUT]) |=> !st_r.flag[CSIE_BIT_PLL_TIMEOUT])
      else $error("Flag clear missed pll timeout");

   a_fclr_pll_gained: assert property (
      (WR_STB && hit(ADDR, CSIE_OFS_FLAG) && WDATA[CSIE_BIT_PLL_GAINED]
       && !rise[CSIE_BIT_PLL_GAINED]) |=> !st_r.flag[CSIE_BIT_PLL_GAINED])
      else $error("Flag clear missed pll gained");

   a_fclr_fll_ready: assert property (
      (WR_STB && hit(ADDR, CSIE_OFS_FLAG) && WDATA[CSIE_BIT_FLL_READY]
       && !rise[CSIE_BIT_FLL_READY]) |=> !st_r.flag[CSIE_BIT_FLL_READY])
      else $error("Flag clear missed fll ready");

   a_fclr_ref8m: assert property (
      (WR_STB && hit(ADDR, CSIE_OFS_FLAG) && WDATA[CSIE_BIT_REF8M_READY]
       && !rise[CSIE_BIT_REF8M_READY]) |=> !st_r.flag[CSIE_BIT_REF8M_READY])
      else $error("Flag clear missed ref8m ready");

   a_fclr_xtal: assert property (
      (WR_STB && hit(ADDR, CSIE_OFS_FLAG) && WDATA[CSIE_BIT_XTAL_READY]
       && !rise[CSIE_BIT_XTAL_READY]) |=> !st_r.flag[CSIE_BIT_XTAL_READY])
      else $error("Flag clear missed xtal ready");

endmodule : csie_top

// File: tb/tb_clock_source_irq_enable_set_clear.sv
`timescale 1ns/10ps
module tb_clock_source_irq_enable_set_clear
   import csie_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        reset_n  = 1'b0;
   logic [7:0]  addr     = 8'h00;
   logic [31:0] wdata    = 32'h0;
   logic        wr_stb   = 1'b0;
   logic        rd_stb   = 1'b0;
   logic [31:0] status   = 32'h0;
   logic [31:0] rdata;
   logic        irq;
   int          errors    = 0;
   int          tests_run = 0;

   always #5 core_clk = ~core_clk;

   csie_top dut_u (
      .CORE_CLK   (core_clk),
      .RESET_N    (reset_n),
      .ADDR       (addr),
      .WDATA      (wdata),
      .WR_STB     (wr_stb),
      .RD_STB     (rd_stb),
      .SRC_STATUS (status),
      .RDATA      (rdata),
      .IRQ        (irq)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t exp=%h got=%h", $time, exp, got);
      end
   endtask : cmp

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rd_cmp(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1 cmp(exp, rdata);
   endtask : rd_cmp

   task automatic irq_cmp(input logic exp);
      @(posedge core_clk);
      #1 cmp({31'h0, exp}, {31'h0, irq});
   endtask : irq_cmp

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rd_cmp(CSIE_OFS_ENSET, 32'h0);
      rd_cmp(CSIE_OFS_ENCLR, 32'h0);
      irq_cmp(1'b0);
   endtask : t_reset

   task automatic t_set;
      wr(CSIE_OFS_ENSET, 32'h0002_0000);
      wr(CSIE_OFS_ENSET, 32'h0000_0100);
      rd_cmp(CSIE_OFS_ENSET, 32'h0002_0100);
      wr(CSIE_OFS_ENSET, 32'hffff_ffff);
      rd_cmp(CSIE_OFS_ENSET, 32'h0003_8fff);
      rd_cmp(CSIE_OFS_ENCLR, 32'h0003_8fff);
      wr(CSIE_OFS_ENSET, 32'h0);
      rd_cmp(CSIE_OFS_ENSET, 32'h0003_8fff);
   endtask : t_set

   task automatic t_clr;
      wr(CSIE_OFS_ENCLR, 32'h0001_0411);
      rd_cmp(CSIE_OFS_ENCLR, 32'h0002_8bee);
      wr(CSIE_OFS_ENCLR, 32'h0);
      rd_cmp(CSIE_OFS_ENSET, 32'h0002_8bee);
      wr(CSIE_OFS_ENCLR, 32'hffff_ffff);
      rd_cmp(CSIE_OFS_ENSET, 32'h0);
   endtask : t_clr

   task automatic t_irq;
      @(posedge core_clk);
      status <= 32'h0000_0010;
      rd_cmp(CSIE_OFS_FLAG, 32'h0000_0010);
      rd_cmp(CSIE_OFS_STATUS, 32'h0000_0010);
      irq_cmp(1'b0);
      wr(CSIE_OFS_ENSET, 32'h0000_0010);
      irq_cmp(1'b1);
      wr(CSIE_OFS_FLAG, 32'h0);
      rd_cmp(CSIE_OFS_FLAG, 32'h0000_0010);
      irq_cmp(1'b1);
      wr(CSIE_OFS_FLAG, 32'h0000_0010);
      irq_cmp(1'b0);
      rd_cmp(CSIE_OFS_FLAG, 32'h0);
      @(posedge core_clk);
      status <= 32'h0;
   endtask : t_irq

   task automatic t_guard;
      wr(CSIE_OFS_GUARD, 32'h1);
      wr(CSIE_OFS_ENSET, 32'hffff_ffff);
      rd_cmp(CSIE_OFS_ENSET, 32'h0000_0010);
      wr(CSIE_OFS_ENCLR, 32'hffff_ffff);
      rd_cmp(CSIE_OFS_ENCLR, 32'h0000_0010);
      wr(CSIE_OFS_GUARD, 32'h0);
      wr(CSIE_OFS_ENCLR, 32'hffff_ffff);
      rd_cmp(CSIE_OFS_ENSET, 32'h0);
   endtask : t_guard

   task automatic t_unmapped;
      wr(8'h20, 32'hffff_ffff);
      rd_cmp(8'h20, 32'h0);
      rd_cmp(CSIE_OFS_ENSET, 32'h0);
   endtask : t_unmapped

   task automatic t_events;
      @(posedge core_clk);
      status <= 32'h0003_8fff;
      rd_cmp(CSIE_OFS_FLAG, 32'h0003_8fff);
      wr(CSIE_OFS_ENSET, 32'h0000_0040);
      rd_cmp(CSIE_OFS_ENSET, 32'h0000_0040);
      irq_cmp(1'b1);
      wr(CSIE_OFS_FLAG, 32'h0003_8fff);
      rd_cmp(CSIE_OFS_FLAG, 32'h0);
      irq_cmp(1'b0);
      wr(CSIE_OFS_ENCLR, 32'h0000_0040);
      @(posedge core_clk);
      status <= 32'h0;
   endtask : t_events

   task automatic complete_run;
      if (errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #50000;
      errors++;
      complete_run();
   end

   initial begin
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      t_reset();
      t_set();
      t_clr();
      t_irq();
      t_guard();
      t_unmapped();
      t_events();
      complete_run();
   end
endmodule : tb_clock_source_irq_enable_set_clear
